/* File: logic/timer_control_16bit_defs.svh */
`ifndef TIMER_CONTROL_16BIT_DEFS_SVH
`define TIMER_CONTROL_16BIT_DEFS_SVH

// Register byte offsets
`define ADDR_W        8
`define OFF_CONTROL   8'h00
`define OFF_COUNT     8'h04
`define OFF_PERIOD    8'h08
`define OFF_STATUS    8'h0c
`define OFF_MASK      8'h10

// Control field positions
`define BIT_RUN       15
`define BIT_HALT_IDLE 13
`define BIT_GATE      6
`define BIT_PRESC_HI  5
`define BIT_PRESC_LO  4
`define BIT_SYNC      2
`define BIT_SRC       1
`define CONTROL_MASK  16'ha076

// Reset values
`define CONTROL_RST   16'h0000
`define COUNT_RST     16'h0000
`define PERIOD_RST    16'hffff

// Prescaler terminal counts (ratio minus one)
`define PRESC_DIV1    8'h00
`define PRESC_DIV8    8'h07
`define PRESC_DIV64   8'h3f
`define PRESC_DIV256  8'hff

// Status bit positions and bus answers
`define EVT_MATCH     0
`define EVT_GATE      1
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

/* File: logic/timer_control_16bit_pkg.sv */
`include "timer_control_16bit_defs.svh"
package timer_control_16bit_pkg;

  // Master to slave half of the register bus
  typedef struct packed {
    logic               awvalid;
    logic [`ADDR_W-1:0] awaddr;
    logic               wvalid;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bready;
    logic               arvalid;
    logic [`ADDR_W-1:0] araddr;
    logic               rready;
  } axiReq_t;

  // Slave to master half of the register bus
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axiRsp_t;

endpackage

/* File: logic/timer_control_16bit.sv */
`timescale 1ns/1ps
`include "timer_control_16bit_defs.svh"
module timer_control_16bit
(
  input  wire logic                             clk_sys,
  input  wire logic                             nrst,
  input  wire timer_control_16bit_pkg::axiReq_t axiReq,
  output      timer_control_16bit_pkg::axiRsp_t axiRsp,
  input  wire logic                             extClkPin,
  input  wire logic                             idleMode,
  input  wire logic                             sleepMode,
  output      logic                             irq
);
  import timer_control_16bit_pkg::*;

  // Whole module state, registered in one place
  typedef struct packed {
    logic               extMeta;
    logic               extSync;
    logic               extPrev;
    logic [15:0]        ctl;
    logic [15:0]        count;
    logic [15:0]        period;
    logic [7:0]         presc;
    logic [1:0]         stat;
    logic [1:0]         mask;
    logic               irq;
    logic               awReady;
    logic               awFull;
    logic [`ADDR_W-1:0] awAddr;
    logic               wReady;
    logic               wFull;
    logic [31:0]        wData;
    logic [3:0]         wStrb;
    logic               bValid;
    logic [1:0]         bResp;
    logic               arReady;
    logic               rValid;
    logic [31:0]        rData;
    logic [1:0]         rResp;
  } state_t;

  localparam state_t STATE_RST = '{
    ctl:     `CONTROL_RST,
    count:   `COUNT_RST,
    period:  `PERIOD_RST,
    awReady: 1'b1,
    wReady:  1'b1,
    arReady: 1'b1,
    default: '0
  };

  state_t     q_q;
  state_t     q_d;
  logic       srcExt;
  logic       gateOn;
  logic       running;
  logic       extRise;
  logic       extFall;
  logic       rawTick;
  logic       prescTick;
  logic [7:0] prescLimit;

  // Merge a write into a 16-bit register by byte lane
  function automatic logic [15:0] mergeLanes(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [15:0] res;
    res = old;
    if (strb[0])
    begin
      res[7:0] = data[7:0];
    end
    if (strb[1])
    begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // Pin edges seen only after both sync stages
  assign extRise = q_q.extSync & ~q_q.extPrev;
  assign extFall = ~q_q.extSync & q_q.extPrev;

  // Source and gating selection
  assign srcExt = q_q.ctl[`BIT_SRC];
  assign gateOn = ~srcExt & q_q.ctl[`BIT_GATE];

  // Async counter mode keeps counting while the core sleeps;
  // synced modes need the cycle clock and stop with it
  assign running = q_q.ctl[`BIT_RUN]
    & ~(idleMode & q_q.ctl[`BIT_HALT_IDLE])
    & ~(sleepMode & ~(srcExt & ~q_q.ctl[`BIT_SYNC]));

  // Timer input: cycle clock, gated cycle clock or pin edges
  assign rawTick = srcExt ? extRise : (gateOn ? q_q.extSync : 1'b1);

  // Prescale ratio select
  always_comb
  begin
    case (q_q.ctl[`BIT_PRESC_HI:`BIT_PRESC_LO])
      2'h0:    prescLimit = `PRESC_DIV1;
      2'h1:    prescLimit = `PRESC_DIV8;
      2'h2:    prescLimit = `PRESC_DIV64;
      default: prescLimit = `PRESC_DIV256;
    endcase
  end

  assign prescTick = running & rawTick & (q_q.presc == prescLimit);

  // Next state of the whole block
  always_comb
  begin
    logic [1:0]  evt;
    logic [1:0]  clr;
    logic [31:0] rd;
    logic        hit;
    evt = 2'h0;
    clr = 2'h0;
    rd = 32'h0;
    hit = 1'b1;
    q_d = q_q;

    // Two-stage synchroniser, then edge history
    q_d.extMeta = extClkPin;
    q_d.extSync = q_q.extMeta;
    q_d.extPrev = q_q.extSync;

    // Prescaler and 16-bit count with period wrap
    if (running & rawTick)
    begin
      q_d.presc = prescTick ? 8'h00 : q_q.presc + 8'h01;
    end
    if (prescTick)
    begin
      if (q_q.count == q_q.period)
      begin
        q_d.count = 16'h0000;
        evt[`EVT_MATCH] = 1'b1;
      end
      else
      begin
        q_d.count = q_q.count + 16'h0001;
      end
    end

    // Gate closing ends an accumulation window
    if (gateOn & extFall & q_q.ctl[`BIT_RUN])
    begin
      evt[`EVT_GATE] = 1'b1;
    end

    // Write channel: address and data taken in either order
    if (q_q.bValid & axiReq.bready)
    begin
      q_d.bValid = 1'b0;
    end
    if (q_q.awReady & axiReq.awvalid)
    begin
      q_d.awFull = 1'b1;
      q_d.awAddr = axiReq.awaddr;
    end
    if (q_q.wReady & axiReq.wvalid)
    begin
      q_d.wFull = 1'b1;
      q_d.wData = axiReq.wdata;
      q_d.wStrb = axiReq.wstrb;
    end

    // Commit a write once both halves are held
    if (q_d.awFull & q_d.wFull & ~q_q.bValid)
    begin
      q_d.awFull = 1'b0;
      q_d.wFull = 1'b0;
      q_d.bValid = 1'b1;
      q_d.bResp = `RESP_OKAY;
      if (q_d.awAddr == `OFF_CONTROL)
      begin
        // Unimplemented bits never store
        q_d.ctl = mergeLanes(q_q.ctl, q_d.wData, q_d.wStrb)
          & `CONTROL_MASK;
        q_d.presc = 8'h00; // Fresh ratio starts from zero
      end
      else if (q_d.awAddr == `OFF_COUNT)
      begin
        q_d.count = mergeLanes(q_q.count, q_d.wData, q_d.wStrb);
      end
      else if (q_d.awAddr == `OFF_PERIOD)
      begin
        q_d.period = mergeLanes(q_q.period, q_d.wData, q_d.wStrb);
      end
      else if (q_d.awAddr == `OFF_STATUS)
      begin
        clr = q_d.wStrb[0] ? q_d.wData[1:0] : 2'h0;
      end
      else if (q_d.awAddr == `OFF_MASK)
      begin
        if (q_d.wStrb[0])
        begin
          q_d.mask = q_d.wData[1:0];
        end
      end
      else
      begin
        q_d.bResp = `RESP_SLVERR;
      end
    end
    q_d.awReady = ~q_d.awFull;
    q_d.wReady = ~q_d.wFull;

    // Sticky flags: a new event beats a clear in the same cycle
    q_d.stat = (q_q.stat & ~clr) | evt;
    q_d.irq = |(q_d.stat & q_d.mask);

    // Read channel: one read outstanding at a time
    if (q_q.rValid & axiReq.rready)
    begin
      q_d.rValid = 1'b0;
      q_d.arReady = 1'b1;
    end
    if (q_q.arReady & axiReq.arvalid)
    begin
      if (axiReq.araddr == `OFF_CONTROL)
      begin
        rd = {16'h0000, q_q.ctl};
      end
      else if (axiReq.araddr == `OFF_COUNT)
      begin
        rd = {16'h0000, q_q.count};
      end
      else if (axiReq.araddr == `OFF_PERIOD)
      begin
        rd = {16'h0000, q_q.period};
      end
      else if (axiReq.araddr == `OFF_STATUS)
      begin
        rd = {30'h0, q_q.stat};
      end
      else if (axiReq.araddr == `OFF_MASK)
      begin
        rd = {30'h0, q_q.mask};
      end
      else
      begin
        hit = 1'b0;
      end
      q_d.rData = rd;
      q_d.rResp = hit ? `RESP_OKAY : `RESP_SLVERR;
      q_d.rValid = 1'b1;
      q_d.arReady = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      q_q <= STATE_RST;
    end
    else
    begin
      q_q <= q_d;
    end
  end

  // Outputs straight from the state register
  assign axiRsp.awready = q_q.awReady;
  assign axiRsp.wready  = q_q.wReady;
  assign axiRsp.bvalid  = q_q.bValid;
  assign axiRsp.bresp   = q_q.bResp;
  assign axiRsp.arready = q_q.arReady;
  assign axiRsp.rvalid  = q_q.rValid;
  assign axiRsp.rdata   = q_q.rData;
  assign axiRsp.rresp   = q_q.rResp;
  assign irq            = q_q.irq;

endmodule

/* File: testbench/timer_control_16bit_sva.sv */
`timescale 1ns/1ps
module timer_control_16bit_sva
(
  input wire logic                             clk_sys,
  input wire logic                             nrst,
  input wire timer_control_16bit_pkg::axiReq_t axiReq,
  input wire timer_control_16bit_pkg::axiRsp_t axiRsp,
  input wire logic                             extClkPin,
  input wire logic                             idleMode,
  input wire logic                             sleepMode,
  input wire logic                             irq
);
  import timer_control_16bit_pkg::*;
  logic [7:0] rdAddr_q;

  // Remember which register a read is for, to judge its data
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      rdAddr_q <= 8'h00;
    else if (axiReq.arvalid && axiRsp.arready)
      rdAddr_q <= axiReq.araddr;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence wrTaken;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  endsequence
  sequence rdOut;
    axiRsp.rvalid;
  endsequence

  chk_write_answer: assert property (wrTaken |=> axiRsp.bvalid)
    else $error("write got no answer");
  chk_b_clears: assert property (axiRsp.bvalid && axiReq.bready
    |=> !axiRsp.bvalid) else $error("bvalid stuck");
  chk_read_answer: assert property (axiReq.arvalid && axiRsp.arready
    |=> rdOut) else $error("read got no answer");
  chk_r_clears: assert property (rdOut ##0 axiReq.rready
    |=> !axiRsp.rvalid && axiRsp.arready) else $error("rvalid stuck");
  chk_ar_blocked: assert property (rdOut |-> !axiRsp.arready)
    else $error("second read taken");
  chk_ctrl_zeros: assert property (
    rdOut ##0 rdAddr_q == 8'h00 |-> (axiRsp.rdata & 32'hffff5f89) == 0)
    else $error("control spare bit set");
  chk_status_bits: assert property (
    rdOut ##0 rdAddr_q == 8'h0c |-> axiRsp.rdata[31:2] == 0)
    else $error("status spare bit set");
  chk_unmapped_err: assert property (rdOut ##0 rdAddr_q > 8'h10
    |-> axiRsp.rresp == 2'h2 && axiRsp.rdata == 0)
    else $error("unmapped read not refused");
endmodule

bind timer_control_16bit timer_control_16bit_sva chk (.clk_sys(clk_sys),
  .nrst(nrst), .axiReq(axiReq), .axiRsp(axiRsp), .extClkPin(extClkPin),
  .idleMode(idleMode), .sleepMode(sleepMode), .irq(irq));

/* File: testbench/ext_pin_model.sv */
`timescale 1ns/1ps
module ext_pin_model
(
  input  wire logic run,
  input  wire logic hold,
  output      logic pin
);
  // Pin clock unrelated to clk_sys; rests low when off, high as a gate
  initial pin = 1'b0;
  always #37 pin = hold | (run & ~pin);
endmodule

/* File: testbench/timer_control_16bit_bench.sv */
`timescale 1ns/1ps
module timer_control_16bit_bench;
  import timer_control_16bit_pkg::*;
  logic        clk_sys;
  logic        nrst;
  axiReq_t     req;
  axiRsp_t     rsp;
  logic        idleMode;
  logic        sleepMode;
  logic        irq;
  logic        pinRun;
  logic        pinHold;
  logic        extClkPin;
  logic [31:0] rd;
  logic [1:0]  resp;
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;
  int          n;

  timer_control_16bit dut (.clk_sys(clk_sys), .nrst(nrst), .axiReq(req),
    .axiRsp(rsp), .extClkPin(extClkPin), .idleMode(idleMode),
    .sleepMode(sleepMode), .irq(irq));
  ext_pin_model pin (.run(pinRun), .hold(pinHold), .pin(extClkPin));

  // Clock and a hang guard
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Both write channels offered at once; ready judged mid-cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk_sys);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(negedge clk_sys);
      ta = rsp.awready & req.awvalid;
      tw = rsp.wready & req.wvalid;
      tb = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge clk_sys);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
    end while (!tb);
    req.bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    logic ta, tb;
    @(posedge clk_sys);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(negedge clk_sys);
      ta = rsp.arready & req.arvalid;
      tb = rsp.rvalid;
      rd = rsp.rdata;
      resp = rsp.rresp;
      @(posedge clk_sys);
      if (ta) req.arvalid <= 1'b0;
    end while (!tb);
    req.rready <= 1'b0;
  endtask

  // Reset values, spare control bits and an unmapped place
  task automatic t_regs();
    rdr(8'h00);
    check(rd, 32'h0);
    rdr(8'h08);
    check(rd, 32'hffff);
    wr(8'h00, 32'hffffffff);
    rdr(8'h00);
    check(rd, 32'ha076);
    wr(8'h14, 32'h1);
    check(resp, 2'h2);
    rdr(8'h14);
    check(resp, 2'h2);
    wr(8'h00, 32'h0);
    $display("regs done");
  endtask

  // Every prescale ratio: period 3 gives a match after 4 ticks
  task automatic t_presc();
    int dv[4] = '{1, 8, 64, 256};
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h3);
      wr(8'h10, 32'h1);
      wr(8'h0c, 32'h3);
      wr(8'h00, 32'h8000 | (i << 4));
      n = 0;
      do
      begin
        @(negedge clk_sys);
        n++;
      end while (!irq);
      check(n >= 4 * dv[i] - 2 && n <= 4 * dv[i] + 6, 1);
    end
    // Mask hides the sticky bit, a one clears it
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h0);
    repeat (2) @(negedge clk_sys);
    check(irq, 1'b0);
    wr(8'h10, 32'h1);
    repeat (2) @(negedge clk_sys);
    check(irq, 1'b1);
    wr(8'h0c, 32'h1);
    repeat (2) @(negedge clk_sys);
    check(irq, 1'b0);
    $display("prescale done");
  endtask

  // Run the timer a while under one set of conditions, see if it moved
  task automatic t_run(input logic [15:0] c, input logic [4:0] v);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    {idleMode, sleepMode, pinRun, pinHold} <= v[4:1];
    wr(8'h00, {16'h0, c});
    repeat (40) @(posedge clk_sys);
    rdr(8'h04);
    check(rd != 0, v[0]);
    $display("run %h done", c);
  endtask

  initial
  begin
    req = '0;
    nrst = 1'b0;
    idleMode = 1'b0;
    sleepMode = 1'b0;
    pinRun = 1'b0;
    pinHold = 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_presc();
    wr(8'h08, 32'hffff);
    t_run(16'h8000, 5'b00001);
    t_run(16'h0000, 5'b00000);
    t_run(16'ha000, 5'b10000);
    t_run(16'h8000, 5'b10001);
    t_run(16'h8040, 5'b00000);
    t_run(16'h8040, 5'b00011);
    pinHold <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rdr(8'h0c);
    check(rd & 2, 2);
    t_run(16'h8042, 5'b00101);
    t_run(16'h8002, 5'b00000);
    t_run(16'h8006, 5'b01100);
    t_run(16'h8002, 5'b01101);
    give_verdict();
  end
endmodule
